// ==== logic/rfdm_config.sv ====
// Operation
// - idle conductance code sits in bits 7..4, used without modulation
// - modulating conductance code sits in bits 3..0, used while modulating
// - soft power-down forces each applied code msb to one
// - idle codes apply only with driver off, else driver-on codes
// - idle codes drive load modulation when answering as card with driver off; with a driver on the driver-on codes do
// - miller pulse lasts width plus one carrier periods; width resets 26h
// - card type a mode uses width for subcarrier duty cycle
// - subcarrier low (width mod 8)+1 periods, high sixteen minus that
// - bit 7 of delay register selects field-derived demodulator clock
// - bits 6..0 add carrier cycles before transmit; register resets 87h
// - bit 7 of receiver config enables level detector amplifier
// - gain field decodes to 18,23,18,23,33,38,43,48 dB
// - bits 3..0 set level detector sensitivity; register resets 48h
// - driver-on codes only while a driver is on, else idle codes
`timescale 1ns/1ps
`include "rfdm_params.svh"
module rfdm_config
    import rfdm_pkg::*;
(
    // clock and reset
    input  wire logic           i_clock,
    input  wire logic           i_rst_b,
    // host register port
    input  wire rfdm_host_req_s i_host,
    output logic [7:0]          o_reg_rdata,
    // driver state and driver-on codes
    input  wire rfdm_ctl_s      i_ctl,
    input  wire rfdm_gsn_s      i_gsn_active,
    // carrier timing
    input  wire logic           i_carrier_tick,
    input  wire logic           i_mod_start,
    input  wire logic           i_tx_request,
    // driver and modulation outputs
    output logic [3:0]          o_n_conductance,
    output logic                o_miller_pulse,
    output logic                o_subcarrier,
    output logic                o_tx_start,
    // receiver front end
    output logic                o_field_derived_demod_clock,
    output logic                o_level_detector_amp_enable,
    output logic [5:0]          o_receiver_gain_db,
    output logic [3:0]          o_level_detector_sensitivity
);

    rfdm_gsn_s   n_driver_conductance_idle_state;
    logic [7:0]  modulation_pulse_width;
    rfdm_delay_s transmit_bit_delay;
    rfdm_rxcfg_s receiver_front_end_config;
    rfdm_gsn_s   next_idle_state;
    logic [7:0]  next_pulse_width;
    rfdm_delay_s next_bit_delay;
    rfdm_rxcfg_s next_rx_cfg;
    logic [7:0]  next_rdata;

    // register writes and reads
    always_comb begin
        next_idle_state  = n_driver_conductance_idle_state;
        next_pulse_width = modulation_pulse_width;
        next_bit_delay   = transmit_bit_delay;
        next_rx_cfg      = receiver_front_end_config;
        next_rdata       = o_reg_rdata;
        if (i_host.wr) begin
            unique case (i_host.addr)
                `RFDM_ADDR_GSN_OFF:      next_idle_state  = i_host.wdata;
                `RFDM_ADDR_MOD_WIDTH:    next_pulse_width = i_host.wdata;
                `RFDM_ADDR_TX_BIT_DELAY: next_bit_delay   = i_host.wdata;
                `RFDM_ADDR_RX_CFG:       next_rx_cfg      = i_host.wdata;
                default: ;
            endcase
        end
        if (i_host.rd) begin
            unique case (i_host.addr)
                `RFDM_ADDR_GSN_OFF:      next_rdata = n_driver_conductance_idle_state;
                `RFDM_ADDR_MOD_WIDTH:    next_rdata = modulation_pulse_width;
                `RFDM_ADDR_TX_BIT_DELAY: next_rdata = transmit_bit_delay;
                `RFDM_ADDR_RX_CFG:       next_rdata = receiver_front_end_config;
                default:                 next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            n_driver_conductance_idle_state <= `RFDM_RST_GSN_OFF;
            modulation_pulse_width          <= `RFDM_RST_MOD_WIDTH;
            transmit_bit_delay              <= `RFDM_RST_TX_BIT_DELAY;
            receiver_front_end_config       <= `RFDM_RST_RX_CFG;
            o_reg_rdata                     <= 8'h00;
        end else begin
            n_driver_conductance_idle_state <= next_idle_state;
            modulation_pulse_width          <= next_pulse_width;
            transmit_bit_delay              <= next_bit_delay;
            receiver_front_end_config       <= next_rx_cfg;
            o_reg_rdata                     <= next_rdata;
        end
    end

    // receiver front end straight from register flops
    assign o_field_derived_demod_clock  = transmit_bit_delay.field_clk;
    assign o_level_detector_amp_enable  = receiver_front_end_config.amp;
    assign o_level_detector_sensitivity = receiver_front_end_config.sens;

    function automatic logic [5:0] gain_db(input logic [2:0] code);
        unique case (code)
            3'b000, 3'b010: gain_db = 6'd18;
            3'b001, 3'b011: gain_db = 6'd23;
            3'b100:         gain_db = 6'd33;
            3'b101:         gain_db = 6'd38;
            3'b110:         gain_db = 6'd43;
            3'b111:         gain_db = 6'd48;
        endcase
    endfunction

    logic [5:0] next_gain_db;
    logic [3:0] next_n_cond;
    rfdm_gsn_s  sel_codes;
    logic       use_mod_code;

    // conductance selection
    always_comb begin
        next_gain_db = gain_db(next_rx_cfg.gain);
        use_mod_code = i_ctl.modulating
                    || (i_ctl.card_mode_a && i_ctl.load_modulation_a);
        if (i_ctl.driver_on) begin
            sel_codes = i_gsn_active;
        end else begin
            sel_codes = n_driver_conductance_idle_state;
        end
        next_n_cond = use_mod_code ? sel_codes.modul : sel_codes.unmod;
        if (i_ctl.soft_pd) begin
            next_n_cond[3] = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_receiver_gain_db <= 6'd33;
            o_n_conductance    <= 4'h0;
        end else begin
            o_receiver_gain_db <= next_gain_db;
            o_n_conductance    <= next_n_cond;
        end
    end

    // miller pulse timing
    logic pulse_load;
    logic pulse_busy;

    assign pulse_load = i_mod_start && i_ctl.initiator && !i_ctl.card_mode_a;

    rfdm_carrier_counter #(
        .W(8)
    ) u_pulse (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_load  (pulse_load),
        .i_count (modulation_pulse_width),
        .i_tick  (i_carrier_tick),
        .o_busy  (pulse_busy),
        .o_done  ()
    );

    assign o_miller_pulse = pulse_busy;

    // subcarrier duty cycle
    logic [3:0] subc_phase;
    logic [3:0] next_subc_phase;
    logic [3:0] low_count;
    logic       next_subc;

    always_comb begin
        low_count       = {1'b0, modulation_pulse_width[2:0]} + 4'h1;
        next_subc_phase = subc_phase;
        if (!i_ctl.card_mode_a) begin
            next_subc_phase = 4'h0;
        end else if (i_carrier_tick) begin
            next_subc_phase = subc_phase + 4'h1;
        end
        next_subc = i_ctl.card_mode_a && (next_subc_phase >= low_count);
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            subc_phase   <= 4'h0;
            o_subcarrier <= 1'b0;
        end else begin
            subc_phase   <= next_subc_phase;
            o_subcarrier <= next_subc;
        end
    end

    // transmit start delay
    rfdm_tx_e   tx_state;
    rfdm_tx_e   next_tx_state;
    logic       delay_load;
    logic       delay_done;
    logic [6:0] delay_count;
    logic       next_tx_start;

    always_comb begin
        next_tx_state = tx_state;
        delay_load    = 1'b0;
        delay_count   = transmit_bit_delay.cycles - 7'd1;
        next_tx_start = 1'b0;
        unique case (tx_state)
            RFDM_TX_IDLE: begin
                if (i_tx_request) begin
                    if (transmit_bit_delay.cycles == 7'd0) begin
                        next_tx_state = RFDM_TX_GO;
                        next_tx_start = 1'b1;
                    end else begin
                        delay_load    = 1'b1;
                        next_tx_state = RFDM_TX_WAIT;
                    end
                end
            end
            RFDM_TX_WAIT: begin
                if (delay_done) begin
                    next_tx_state = RFDM_TX_GO;
                    next_tx_start = 1'b1;
                end
            end
            RFDM_TX_GO: begin
                next_tx_state = RFDM_TX_IDLE;
            end
            default: next_tx_state = RFDM_TX_IDLE;
        endcase
    end

    rfdm_carrier_counter #(
        .W(7)
    ) u_delay (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_load  (delay_load),
        .i_count (delay_count),
        .i_tick  (i_carrier_tick),
        .o_busy  (),
        .o_done  (delay_done)
    );

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_state   <= RFDM_TX_IDLE;
            o_tx_start <= 1'b0;
        end else begin
            tx_state   <= next_tx_state;
            o_tx_start <= next_tx_start;
        end
    end

    // checking helpers
    logic [8:0] pulse_ticks;
    logic [7:0] pulse_width_cap;
    logic [7:0] delay_ticks;
    logic [6:0] delay_cap;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pulse_ticks     <= 9'h000;
            pulse_width_cap <= 8'h00;
            delay_ticks     <= 8'h00;
            delay_cap       <= 7'h00;
        end else begin
            if (pulse_load) begin
                pulse_ticks     <= 9'h000;
                pulse_width_cap <= modulation_pulse_width;
            end else if (pulse_busy && i_carrier_tick) begin
                pulse_ticks <= pulse_ticks + 9'h001;
            end
            if (tx_state == RFDM_TX_IDLE && i_tx_request) begin
                delay_ticks <= 8'h00;
                delay_cap   <= transmit_bit_delay.cycles;
            end else if (tx_state == RFDM_TX_WAIT && i_carrier_tick) begin
                delay_ticks <= delay_ticks + 8'h01;
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    idle_code_sel_a: assert property (
        !i_ctl.driver_on && !i_ctl.soft_pd && !i_ctl.modulating && !i_ctl.card_mode_a
        |=> o_n_conductance == $past(n_driver_conductance_idle_state.unmod))
        else $error("idle unmodulated code not applied");
    mod_code_sel_a: assert property (
        !i_ctl.driver_on && !i_ctl.soft_pd && i_ctl.modulating
        |=> o_n_conductance == $past(n_driver_conductance_idle_state.modul))
        else $error("idle modulating code not applied");
    pd_force_msb_a: assert property (
        i_ctl.soft_pd |=> o_n_conductance[3])
        else $error("soft power-down msb not forced");
    active_code_sel_a: assert property (
        i_ctl.driver_on && !i_ctl.soft_pd && !i_ctl.modulating && !i_ctl.card_mode_a
        |=> o_n_conductance == $past(i_gsn_active.unmod))
        else $error("driver-on code not applied");
    load_mod_code_a: assert property (
        !i_ctl.driver_on && !i_ctl.soft_pd && i_ctl.card_mode_a && i_ctl.load_modulation_a
        |=> o_n_conductance == $past(n_driver_conductance_idle_state.modul))
        else $error("load modulation code not applied");
    miller_len_a: assert property (
        $fell(o_miller_pulse) && !$past(pulse_load)
        |-> pulse_ticks == {1'b0, pulse_width_cap} + 9'd1)
        else $error("miller pulse length wrong");
    subc_level_a: assert property (
        i_ctl.card_mode_a && $past(i_ctl.card_mode_a) && $stable(modulation_pulse_width)
        |-> o_subcarrier == (subc_phase >= low_count))
        else $error("subcarrier level wrong for phase");
    subc_off_a: assert property (
        !i_ctl.card_mode_a |=> !o_subcarrier)
        else $error("subcarrier active outside card mode");
    tx_delay_len_a: assert property (
        $rose(o_tx_start) |-> delay_ticks == {1'b0, delay_cap})
        else $error("transmit delay length wrong");
    gain_decode_a: assert property (
        receiver_front_end_config.gain == 3'b010 && $stable(receiver_front_end_config)
        |-> o_receiver_gain_db == 6'd18)
        else $error("gain decode wrong");
    read_back_a: assert property (
        i_host.wr && i_host.addr == `RFDM_ADDR_MOD_WIDTH
        ##1 (i_host.rd && !i_host.wr && i_host.addr == `RFDM_ADDR_MOD_WIDTH)
        |=> o_reg_rdata == $past(i_host.wdata, 2))
        else $error("read back differs from write");

    miller_seen_c: cover property ($fell(o_miller_pulse));
    subc_cycle_c:  cover property ($rose(o_subcarrier) ##[1:100] $fell(o_subcarrier));
    tx_delayed_c:  cover property (tx_state == RFDM_TX_WAIT ##[1:1000] o_tx_start);
    pd_forced_c:   cover property (i_ctl.soft_pd && !n_driver_conductance_idle_state.unmod[3]);

endmodule

// ==== logic/rfdm_params.svh ====
`ifndef RFDM_PARAMS_SVH
`define RFDM_PARAMS_SVH

// register addresses on the host register port
`define RFDM_ADDR_W            6
`define RFDM_ADDR_GSN_OFF      6'h23
`define RFDM_ADDR_MOD_WIDTH    6'h24
`define RFDM_ADDR_TX_BIT_DELAY 6'h25
`define RFDM_ADDR_RX_CFG       6'h26

// reset values
`define RFDM_RST_GSN_OFF       8'h88
`define RFDM_RST_MOD_WIDTH     8'h26
`define RFDM_RST_TX_BIT_DELAY  8'h87
`define RFDM_RST_RX_CFG        8'h48

// field positions
`define RFDM_GSN_UNMOD_MSB     7
`define RFDM_GSN_UNMOD_LSB     4
`define RFDM_GSN_MOD_MSB       3
`define RFDM_GSN_MOD_LSB       0
`define RFDM_DELAY_CLK_BIT     7
`define RFDM_DELAY_CYC_MSB     6
`define RFDM_AMP_BIT           7
`define RFDM_GAIN_MSB          6
`define RFDM_GAIN_LSB          4
`define RFDM_SENS_MSB          3

// subcarrier timing in carrier periods
`define RFDM_SUBC_PERIOD       16
`define RFDM_SUBC_LOW_MODULO   8

`endif

// ==== logic/rfdm_pkg.sv ====
package rfdm_pkg;

    typedef struct packed {
        logic [3:0] unmod;
        logic [3:0] modul;
    } rfdm_gsn_s;

    typedef struct packed {
        logic       field_clk;
        logic [6:0] cycles;
    } rfdm_delay_s;

    typedef struct packed {
        logic       amp;
        logic [2:0] gain;
        logic [3:0] sens;
    } rfdm_rxcfg_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rfdm_host_req_s;

    typedef struct packed {
        logic soft_pd;
        logic driver_on;
        logic modulating;
        logic load_modulation_a;
        logic initiator;
        logic card_mode_a;
    } rfdm_ctl_s;

    typedef enum logic [1:0] {
        RFDM_TX_IDLE = 2'b00,
        RFDM_TX_WAIT = 2'b01,
        RFDM_TX_GO   = 2'b11
    } rfdm_tx_e;

endpackage

// ==== logic/rfdm_carrier_counter.sv ====
`timescale 1ns/1ps
module rfdm_carrier_counter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst_b,
    // control
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    input  wire logic         i_tick,
    // status
    output logic              o_busy,
    output logic              o_done
);

    logic [W-1:0] remaining;
    logic [W-1:0] next_remaining;
    logic         next_busy;
    logic         next_done;

    // runs for i_count+1 carrier ticks after a load
    always_comb begin
        next_remaining = remaining;
        next_busy      = o_busy;
        next_done      = 1'b0;
        if (i_load) begin
            next_busy      = 1'b1;
            next_remaining = i_count;
        end else if (o_busy && i_tick) begin
            if (remaining == '0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_remaining = remaining - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            remaining <= '0;
            o_busy    <= 1'b0;
            o_done    <= 1'b0;
        end else begin
            remaining <= next_remaining;
            o_busy    <= next_busy;
            o_done    <= next_done;
        end
    end

endmodule

// ==== testbench/rf_driver_modulation_config_bench.sv ====
`timescale 1ns/1ps
`include "rfdm_params.svh"
module rf_driver_modulation_config_bench
    import rfdm_pkg::*;
;
    // clock, reset and host side
    logic           i_clock;
    logic           i_rst_b;
    rfdm_host_req_s host;
    logic [7:0]     reg_rdata;
    // mode and carrier events
    rfdm_ctl_s      ctl;
    rfdm_gsn_s      gsn_active;
    logic           carrier_tick;
    logic           mod_start;
    logic           tx_request;
    // observed outputs
    logic [3:0]     n_cond;
    logic           miller;
    logic           subc;
    logic           tx_start;
    logic           demod_clk;
    logic           amp_en;
    logic [5:0]     gain_db;
    logic [3:0]     sens;
    int             num_errors;
    int             num_checks;
    int             gains [8] = '{18, 23, 18, 23, 33, 38, 43, 48};
    int             n;
    int             g;
    int             lows;
    logic [7:0]     w;

    rfdm_config i_rfdm_config (
        .i_clock                      (i_clock),
        .i_rst_b                      (i_rst_b),
        .i_host                       (host),
        .o_reg_rdata                  (reg_rdata),
        .i_ctl                        (ctl),
        .i_gsn_active                 (gsn_active),
        .i_carrier_tick               (carrier_tick),
        .i_mod_start                  (mod_start),
        .i_tx_request                 (tx_request),
        .o_n_conductance              (n_cond),
        .o_miller_pulse               (miller),
        .o_subcarrier                 (subc),
        .o_tx_start                   (tx_start),
        .o_field_derived_demod_clock  (demod_clk),
        .o_level_detector_amp_enable  (amp_en),
        .o_receiver_gain_db           (gain_db),
        .o_level_detector_sensitivity (sens)
    );

    always #25 i_clock = ~i_clock;

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_clock);
        host.wr    = 1'b1;
        host.addr  = a;
        host.wdata = d;
        @(negedge i_clock);
        host.wr    = 1'b0;
    endtask

    task automatic rd_check(input logic [5:0] a, input logic [7:0] exp);
        @(negedge i_clock);
        host.rd   = 1'b1;
        host.addr = a;
        @(negedge i_clock);
        host.rd   = 1'b0;
        @(negedge i_clock);
        check(reg_rdata, exp);
    endtask

    // ctl bits: soft_pd, driver_on, modulating, load_mod, initiator, card
    task automatic cond_is(input logic [5:0] c, input logic [3:0] exp);
        @(negedge i_clock);
        ctl = c;
        repeat (2) @(negedge i_clock);
        check({4'h0, n_cond}, {4'h0, exp});
    endtask

    // ticks every fourth cycle until the pulse ends or transmit starts
    task automatic count_ticks(input bit want_tx, output int cnt);
        int  i;
        bit  met;
        cnt = 0;
        met = 1'b0;
        for (i = 0; i < 600 && !met; i++) begin
            met = want_tx ? (tx_start === 1'b1) : (miller === 1'b0);
            carrier_tick = !met && (i % 4 == 3);
            cnt += int'(carrier_tick);
            if (!met)
                @(negedge i_clock);
        end
        if (!met) begin
            num_errors++;
            stop_test();
        end
    endtask

    initial begin
        i_clock      = 1'b0;
        i_rst_b      = 1'b0;
        host         = '0;
        ctl          = '0;
        gsn_active   = 8'h34;
        carrier_tick = 1'b0;
        mod_start    = 1'b0;
        tx_request   = 1'b0;
        num_errors   = 0;
        num_checks   = 0;
        repeat (10) @(negedge i_clock);
        i_rst_b = 1'b1;
        repeat (3) @(negedge i_clock);
        // reset values and decoded outputs
        rd_check(`RFDM_ADDR_GSN_OFF, 8'h88);
        rd_check(`RFDM_ADDR_MOD_WIDTH, 8'h26);
        rd_check(`RFDM_ADDR_TX_BIT_DELAY, 8'h87);
        rd_check(`RFDM_ADDR_RX_CFG, 8'h48);
        rd_check(6'h27, 8'h00);
        check({7'h0, demod_clk}, 8'h01);
        check({7'h0, amp_en}, 8'h00);
        check({2'h0, gain_db}, 8'd33);
        check({4'h0, sens}, 8'h08);
        check({4'h0, n_cond}, 8'h08);
        // conductance selection
        wr_reg(`RFDM_ADDR_GSN_OFF, 8'h51);
        rd_check(`RFDM_ADDR_GSN_OFF, 8'h51);
        cond_is(6'b000000, 4'h5);
        cond_is(6'b001000, 4'h1);
        cond_is(6'b000101, 4'h1);
        cond_is(6'b100000, 4'hd);
        cond_is(6'b101000, 4'h9);
        cond_is(6'b010000, 4'h3);
        cond_is(6'b011000, 4'h4);
        cond_is(6'b110000, 4'hb);
        cond_is(6'b000000, 4'h5);
        // receiver front end, every gain code
        for (g = 0; g < 8; g++) begin
            wr_reg(`RFDM_ADDR_RX_CFG, {1'b0, 3'(g), 4'h5});
            repeat (2) @(negedge i_clock);
            check({2'h0, gain_db}, 8'(gains[g]));
            check({4'h0, sens}, 8'h05);
        end
        wr_reg(`RFDM_ADDR_RX_CFG, 8'h80);
        repeat (2) @(negedge i_clock);
        check({7'h0, amp_en}, 8'h01);
        rd_check(`RFDM_ADDR_RX_CFG, 8'h80);
        // back to back write then read
        @(negedge i_clock);
        host.wr    = 1'b1;
        host.addr  = `RFDM_ADDR_MOD_WIDTH;
        host.wdata = 8'h55;
        @(negedge i_clock);
        host.wr    = 1'b0;
        host.rd    = 1'b1;
        @(negedge i_clock);
        host.rd    = 1'b0;
        check(reg_rdata, 8'h55);
        // miller pulse width, initiator only
        ctl = 6'b000010;
        for (g = 0; g < 2; g++) begin
            w = (g == 0) ? 8'h00 : 8'h03;
            wr_reg(`RFDM_ADDR_MOD_WIDTH, w);
            @(negedge i_clock);
            mod_start = 1'b1;
            @(negedge i_clock);
            mod_start = 1'b0;
            check({7'h0, miller}, 8'h01);
            count_ticks(1'b0, n);
            check(8'(n), w + 8'h01);
        end
        ctl = 6'b000011;
        @(negedge i_clock);
        mod_start = 1'b1;
        @(negedge i_clock);
        mod_start = 1'b0;
        @(negedge i_clock);
        check({7'h0, miller}, 8'h00);
        // subcarrier duty cycle in card mode
        wr_reg(`RFDM_ADDR_MOD_WIDTH, 8'h0b);
        ctl  = 6'b000001;
        lows = 0;
        for (g = 0; g < 128; g++) begin
            @(negedge i_clock);
            if (g % 4 == 2)
                lows += int'(subc === 1'b0);
            carrier_tick = (g % 4 == 3) && (g != 127);
        end
        check(8'(lows), 8'd8);
        ctl = 6'b000000;
        repeat (3) @(negedge i_clock);
        check({7'h0, subc}, 8'h00);
        // transmit delay, zero and non-zero
        for (g = 0; g < 2; g++) begin
            w = (g == 0) ? 8'h00 : 8'h05;
            wr_reg(`RFDM_ADDR_TX_BIT_DELAY, w);
            @(negedge i_clock);
            tx_request = 1'b1;
            @(negedge i_clock);
            tx_request = 1'b0;
            count_ticks(1'b1, n);
            check(8'(n), w);
            @(negedge i_clock);
            check({7'h0, tx_start}, 8'h00);
        end
        check({7'h0, demod_clk}, 8'h00);
        stop_test();
    end
endmodule
